/* hw/uotg_regs.svh */
// Register offsets, field positions, reset values and timing counts of the USB OTG status block.
// Assumes inclusion by bare name from the package and the design; definitions only.
`ifndef UOTG_REGS_SVH
`define UOTG_REGS_SVH

// Byte offsets on the APB register bus
`define UOTG_OFS_LINE_STATUS 12'h000
`define UOTG_OFS_CONTROL 12'h004
`define UOTG_OFS_IRQ_STATUS 12'h008
`define UOTG_OFS_IRQ_MASK 12'h00C
`define UOTG_OFS_LINK_CTRL 12'h010
`define UOTG_OFS_TOKEN 12'h014

// Line status field positions
`define UOTG_LS_CABLE_ID 7
`define UOTG_LS_STABLE 5
`define UOTG_LS_SESS_VALID 3
`define UOTG_LS_SESS_END 2
`define UOTG_LS_BUS_POWER 0

// Control field positions
`define UOTG_CTL_ENABLE 0
`define UOTG_CTL_PP_RESET 1
`define UOTG_CTL_HOST_MODE 3
`define UOTG_CTL_RESUME 5
`define UOTG_CTL_SE0 6
`define UOTG_CTL_IDLE 7
`define UOTG_CTL_TOKEN_BUSY 8

// Link control field positions
`define UOTG_LINK_ROLE_A 0

// Interrupt event positions
`define UOTG_IRQ_FRAME 0
`define UOTG_IRQ_ID_CHANGE 1
`define UOTG_IRQ_STABLE 2
`define UOTG_IRQ_SESSION 3
`define UOTG_IRQ_WIDTH 4

// Reset values
`define UOTG_CONTROL_RESET 32'h0000_0000
`define UOTG_MASK_RESET 4'h0

// Timing: one millisecond at a 50 ns clock period
`define UOTG_CLK_PERIOD_NS 50
`define UOTG_MS_NS 1000000
`define UOTG_MS_CYCLES (`UOTG_MS_NS / `UOTG_CLK_PERIOD_NS)

`endif

/* hw/uotg_pkg.sv */
// Types shared by the USB OTG status and control block.
// Assumes the constants header sits beside it.
`include "uotg_regs.svh"

package uotg_pkg;

	// Cable, bus-power and line-state indications sampled from the analog front end
	typedef struct packed {
		logic cable_id;
		logic vbus_above_session;
		logic line_se0;
		logic line_idle;
	} uotg_phy_t;

	// Resume signalling sequencer
	typedef enum logic [1:0] {
		UOTG_RS_IDLE,
		UOTG_RS_DRIVE,
		UOTG_RS_EOP
	} uotg_resume_t;

endpackage

/* hw/uotg_status_ctrl.sv */
// USB OTG status and partial control: line status, session levels, frame marker timer,
// ping-pong pointer reset, host logic reset and resume end-of-packet, with an APB slave.
// Assumes synchronous PHY level inputs and one 20 MHz clock with synchronous reset.
// Pointer banks and the token engine sit outside; only their strobes and the token command byte leave here.
//
// Behaviour
// - Cable id bit reads the sensed pin
// - Stable flag after 1 ms unchanged line
// - Session valid when bus above level
// - Session end in B role below level
// - Bus power valid in A role above
// - Other status bits zero, read-only, reset zero
// - Writing one resets ping-pong pointers
// - Device mode enable bit powers module
// - Host mode frame marker every 1 ms
// - Host bit change resets host logic
// - Host resume end appends low-speed EOP
`timescale 1ns/100ps
`include "uotg_regs.svh"

module uotg_status_ctrl (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire uotg_pkg::uotg_phy_t PHY,
	input wire logic TOKEN_DONE,
	output logic MODULE_ON,
	output logic PP_PTR_RESET,
	output logic HOST_LOGIC_RESET,
	output logic FRAME_MARKER,
	output logic RESUME_DRIVE,
	output logic LS_EOP,
	output logic [7:0] TOKEN_CMD,
	output logic TOKEN_GO,
	output logic IRQ
);

	// Stored registers and the status word
	logic [31:0] control;
	logic [31:0] line_status;
	logic [`UOTG_IRQ_WIDTH-1:0] irq_status;
	logic [`UOTG_IRQ_WIDTH-1:0] irq_mask;
	logic [`UOTG_IRQ_WIDTH-1:0] events;
	logic role_a;
	logic token_busy;

	// Timers and registered copies used for change detection
	logic [1:0] line_prev;
	logic [14:0] stable_count;
	logic line_stable;
	logic [14:0] frame_count;
	logic host_prev;
	logic id_prev;
	logic sess_prev;
	logic stable_prev;
	uotg_pkg::uotg_resume_t resume_state;

	// Bus decode
	logic wr;
	logic rd;
	logic mapped;
	logic [31:0] next_rdata;
	logic host_mode;

	// Last count of a 1 ms span; both timers share it so they agree exactly
	localparam logic [14:0] MS_LAST = 15'(`UOTG_MS_CYCLES - 1);

	// Access phase strobes; every access completes in its first access cycle
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && PENABLE && !PWRITE;
	assign host_mode = control[`UOTG_CTL_HOST_MODE];

	// Status word: unimplemented bits are constant zero
	// Levels are read live, so a read shows the pins as of its setup cycle
	always_comb begin
		line_status = 32'h0000_0000;
		line_status[`UOTG_LS_CABLE_ID] = PHY.cable_id;
		line_status[`UOTG_LS_STABLE] = line_stable;
		line_status[`UOTG_LS_SESS_VALID] = PHY.vbus_above_session;
		line_status[`UOTG_LS_SESS_END] = !role_a && !PHY.vbus_above_session;
		line_status[`UOTG_LS_BUS_POWER] = role_a && PHY.vbus_above_session;
	end

	// Read mux; unmapped addresses read zero and flag an error
	// No wait states, so the mux works from the setup-cycle address
	always_comb begin
		next_rdata = 32'h0000_0000;
		mapped = 1'b1;
		case (PADDR)
			`UOTG_OFS_LINE_STATUS: next_rdata = line_status;
			`UOTG_OFS_CONTROL: begin
				next_rdata = control;
				next_rdata[`UOTG_CTL_TOKEN_BUSY] = token_busy;
			end
			`UOTG_OFS_IRQ_STATUS: next_rdata[`UOTG_IRQ_WIDTH-1:0] = irq_status;
			`UOTG_OFS_IRQ_MASK: next_rdata[`UOTG_IRQ_WIDTH-1:0] = irq_mask;
			`UOTG_OFS_LINK_CTRL: next_rdata[`UOTG_LINK_ROLE_A] = role_a;
			`UOTG_OFS_TOKEN: next_rdata[7:0] = TOKEN_CMD;
			default: mapped = 1'b0;
		endcase
	end

	// Bus answer registers
	// Answers are registered at setup so PREADY is a clean flop output
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && !mapped;
			PRDATA <= (PSEL && !PENABLE && !PWRITE) ? next_rdata : 32'h0000_0000;
		end
	end

	// Control register; ping-pong reset bit is self-clearing, writing zero does nothing
	// Writes land at the ready edge only; any other cycle only clears the ping-pong reset bit
	// Busy is never stored here; the read mux supplies it live
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			control <= `UOTG_CONTROL_RESET;
			role_a <= 1'b0;
			irq_mask <= `UOTG_MASK_RESET;
		end else begin
			control[`UOTG_CTL_PP_RESET] <= 1'b0;
			if (wr && PREADY && PADDR == `UOTG_OFS_CONTROL) begin
				control <= PWDATA;
				control[`UOTG_CTL_TOKEN_BUSY] <= 1'b0;
				control[31:9] <= 23'h00_0000;
			end
			if (wr && PREADY && PADDR == `UOTG_OFS_LINK_CTRL) begin
				role_a <= PWDATA[`UOTG_LINK_ROLE_A];
			end
			if (wr && PREADY && PADDR == `UOTG_OFS_IRQ_MASK) begin
				irq_mask <= PWDATA[`UOTG_IRQ_WIDTH-1:0];
			end
		end
	end

	// Token command: busy from the write until the engine reports done
	// A write while busy is dropped, so software must poll busy first
	// A host logic reset also frees busy, since the engine restarts with it
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			TOKEN_CMD <= 8'h00;
			TOKEN_GO <= 1'b0;
			token_busy <= 1'b0;
		end else begin
			TOKEN_GO <= 1'b0;
			if (wr && PREADY && PADDR == `UOTG_OFS_TOKEN && !token_busy) begin
				TOKEN_CMD <= PWDATA[7:0];
				TOKEN_GO <= 1'b1;
				token_busy <= 1'b1;
			end else if (TOKEN_DONE || HOST_LOGIC_RESET) begin
				token_busy <= 1'b0;
			end
		end
	end

	// Line stability timer: restarts on any change of SE0 or idle level
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			// Copy follows the line in reset, so release is not taken as a change
			line_prev <= {PHY.line_se0, PHY.line_idle};
			stable_count <= 15'h0000;
			line_stable <= 1'b0;
		end else begin
			line_prev <= {PHY.line_se0, PHY.line_idle};
			if (line_prev != {PHY.line_se0, PHY.line_idle}) begin
				stable_count <= 15'h0000;
				line_stable <= 1'b0;
			end else if (stable_count == MS_LAST) begin
				line_stable <= 1'b1;
			end else begin
				stable_count <= stable_count + 15'h0001;
			end
		end
	end

	// Host logic reset pulse on every toggle of the host bit
	// Pulse lags the bit by a cycle; the frame timer sees it one edge later
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			host_prev <= 1'b0;
			HOST_LOGIC_RESET <= 1'b0;
		end else begin
			host_prev <= host_mode;
			HOST_LOGIC_RESET <= host_prev != host_mode;
		end
	end

	// Enables and pointer reset outputs
	// Host mode turns the enable bit into the frame marker enable only
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			MODULE_ON <= 1'b0;
			PP_PTR_RESET <= 1'b0;
		end else begin
			MODULE_ON <= !host_mode && control[`UOTG_CTL_ENABLE];
			PP_PTR_RESET <= control[`UOTG_CTL_PP_RESET];
		end
	end

	// Frame marker: one pulse per millisecond while enabled in host mode
	// Counter restarts on host reset so the first marker is a full span away
	always_ff @(posedge CLOCK) begin
		if (RESET || HOST_LOGIC_RESET || !host_mode || !control[`UOTG_CTL_ENABLE]) begin
			frame_count <= 15'h0000;
			FRAME_MARKER <= 1'b0;
		end else if (frame_count == MS_LAST) begin
			frame_count <= 15'h0000;
			FRAME_MARKER <= 1'b1;
		end else begin
			frame_count <= frame_count + 15'h0001;
			FRAME_MARKER <= 1'b0;
		end
	end

	// Resume: drive while set; in host mode a one-cycle low-speed EOP follows the clear
	// Duration of the resume is timed by software, not here
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			resume_state <= uotg_pkg::UOTG_RS_IDLE;
			RESUME_DRIVE <= 1'b0;
			LS_EOP <= 1'b0;
		end else begin
			case (resume_state)
				uotg_pkg::UOTG_RS_IDLE: begin
					LS_EOP <= 1'b0;
					if (control[`UOTG_CTL_RESUME]) begin
						resume_state <= uotg_pkg::UOTG_RS_DRIVE;
						RESUME_DRIVE <= 1'b1;
					end
				end
				uotg_pkg::UOTG_RS_DRIVE: begin
					// Only a host appends the EOP; a device simply stops driving
					if (!control[`UOTG_CTL_RESUME]) begin
						RESUME_DRIVE <= 1'b0;
						resume_state <= host_mode ? uotg_pkg::UOTG_RS_EOP : uotg_pkg::UOTG_RS_IDLE;
						LS_EOP <= host_mode;
					end
				end
				uotg_pkg::UOTG_RS_EOP: begin
					LS_EOP <= 1'b0;
					resume_state <= uotg_pkg::UOTG_RS_IDLE;
				end
				default: resume_state <= uotg_pkg::UOTG_RS_IDLE;
			endcase
		end
	end

	// Event sources, edge detected against a registered copy
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			// Copies track the pins in reset, so release raises no false change event
			// An absent cable idles high, so a constant reset value would misfire
			id_prev <= PHY.cable_id;
			sess_prev <= PHY.vbus_above_session;
			stable_prev <= 1'b0;
		end else begin
			id_prev <= PHY.cable_id;
			sess_prev <= PHY.vbus_above_session;
			stable_prev <= line_stable;
		end
	end

	// Events are one-cycle strobes into the sticky status
	always_comb begin
		events = '0;
		events[`UOTG_IRQ_FRAME] = FRAME_MARKER;
		events[`UOTG_IRQ_ID_CHANGE] = id_prev != PHY.cable_id;
		events[`UOTG_IRQ_STABLE] = line_stable && !stable_prev;
		events[`UOTG_IRQ_SESSION] = sess_prev != PHY.vbus_above_session;
	end

	// Sticky status cleared by a read; a new event in the read cycle wins
	// IRQ lags the status by one cycle to stay a flop output
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			irq_status <= '0;
			IRQ <= 1'b0;
		end else begin
			if (rd && PREADY && PADDR == `UOTG_OFS_IRQ_STATUS) begin
				irq_status <= events;
			end else begin
				irq_status <= irq_status | events;
			end
			IRQ <= |(irq_status & irq_mask);
		end
	end

endmodule // uotg_status_ctrl

/* testbench/uotg_monitor.sv */
// Port checker for the USB OTG status block.
// Assumes one clock with synchronous active-high reset.
`timescale 1ns/100ps
`include "uotg_regs.svh"
module uotg_monitor (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire uotg_pkg::uotg_phy_t PHY,
	input wire logic MODULE_ON,
	input wire logic PP_PTR_RESET,
	input wire logic HOST_LOGIC_RESET,
	input wire logic FRAME_MARKER,
	input wire logic LS_EOP
);
	logic [14:0] gap;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	sequence s_rd_status;
		PSEL && PENABLE && PREADY && !PWRITE && PADDR == `UOTG_OFS_LINE_STATUS;
	endsequence
	sequence s_wr_pp;
		PSEL && PENABLE && PREADY && PWRITE && PADDR == `UOTG_OFS_CONTROL && PWDATA[1];
	endsequence
	// Cycles since last marker; saturates so a first marker is never early
	always_ff @(posedge CLOCK) begin
		if (RESET || gap == 15'h4E20)
			gap <= FRAME_MARKER ? 15'h0000 : 15'h4E20;
		else
			gap <= FRAME_MARKER ? 15'h0000 : gap + 15'h0001;
	end
	a_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no answer in first access cycle");
	a_err_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
		else $error("error flag outside access");
	a_status_bits: assert property (s_rd_status |->
		PRDATA[7] == $past(PHY.cable_id) && PRDATA[3] == $past(PHY.vbus_above_session)
		&& (PRDATA & 32'hFFFF_FF52) == 32'h0000_0000) else $error("status bits wrong");
	a_pp_pulse: assert property (s_wr_pp |-> ##2 PP_PTR_RESET ##1 !PP_PTR_RESET)
		else $error("pointer reset pulse missing");
	a_pp_cause: assert property (PP_PTR_RESET |->
		$past(PSEL && PENABLE && PREADY && PWRITE && PWDATA[1], 2)
		&& $past(PADDR, 2) == `UOTG_OFS_CONTROL) else $error("pointer reset without write");
	a_frame_gap: assert property (FRAME_MARKER |-> gap >= 15'h4E1F)
		else $error("frame marker early");
	a_frame_host: assert property (FRAME_MARKER |-> !MODULE_ON)
		else $error("marker in device mode");
	a_hreset_once: assert property (HOST_LOGIC_RESET |=> !HOST_LOGIC_RESET)
		else $error("host reset too long");
	a_eop_host: assert property (LS_EOP |-> !MODULE_ON ##1 !LS_EOP)
		else $error("end of packet wrong");
endmodule // uotg_monitor
bind uotg_status_ctrl uotg_monitor u_mon (.CLOCK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PWDATA, .PRDATA, .PREADY, .PSLVERR, .PHY, .MODULE_ON, .PP_PTR_RESET,
	.HOST_LOGIC_RESET, .FRAME_MARKER, .LS_EOP);

/* testbench/uotg_cable.sv */
// Far side: cable levels and a token engine.
// Assumes the bench sets wanted levels and answer delay.
`timescale 1ns/100ps
module uotg_cable (
	input wire logic clock,
	input wire uotg_pkg::uotg_phy_t want,
	input wire logic [3:0] delay,
	input wire logic token_go,
	output uotg_pkg::uotg_phy_t phy,
	output logic token_done
);
	logic [3:0] cnt = 4'h0;
	// Levels move only after an edge, as a synchronised front end
	always_ff @(posedge clock)
		phy <= want;
	// Token finishes after a set delay, prompt or slow
	always_ff @(posedge clock) begin
		cnt <= token_go ? delay : cnt - (cnt != 4'h0);
		token_done <= cnt == 4'h1;
	end
endmodule // uotg_cable

/* testbench/tb.sv */
// Bench for the USB OTG status block.
// Assumes design, package and checker compiled first.
`timescale 1ns/100ps
module tb;
	logic CLOCK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd;
	logic PREADY, PSLVERR, TOKEN_DONE, MODULE_ON, PP_PTR_RESET, HOST_LOGIC_RESET, err;
	logic FRAME_MARKER, RESUME_DRIVE, LS_EOP, TOKEN_GO, IRQ, role = 1'b0;
	logic [7:0] TOKEN_CMD;
	uotg_pkg::uotg_phy_t PHY, want = 4'h0;
	int error_cnt = 0, check_count = 0, n;
	uotg_status_ctrl u_dut (.CLOCK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
		.PRDATA, .PREADY, .PSLVERR, .PHY, .TOKEN_DONE, .MODULE_ON, .PP_PTR_RESET,
		.HOST_LOGIC_RESET, .FRAME_MARKER, .RESUME_DRIVE, .LS_EOP, .TOKEN_CMD, .TOKEN_GO, .IRQ);
	uotg_cable u_cable (.clock(CLOCK), .want(want), .delay(4'h6), .token_go(TOKEN_GO),
		.phy(PHY), .token_done(TOKEN_DONE));
	// Clock, and a watchdog well past the planned run
	initial forever #25 CLOCK = ~CLOCK;
	initial begin
		repeat (90000) @(posedge CLOCK);
		error_cnt++;
		final_report();
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; holds the request until the ready edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do @(posedge CLOCK); while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		// Idle edge, so two calls never drive PSEL twice in one step
		@(posedge CLOCK);
	endtask
	task automatic count(ref logic s, input int c);
		n = 0;
		repeat (c) begin
			@(posedge CLOCK);
			n += s === 1'b1;
		end
	endtask
	// Expected status word from the cable state and role
	function automatic logic [31:0] st(input logic s);
		return {24'h00_0000, want.cable_id, 1'b0, s, 1'b0, want.vbus_above_session,
			!role && !want.vbus_above_session, 1'b0, role && want.vbus_above_session};
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		n = $urandom(3);
		repeat (8) @(posedge CLOCK);
		RESET <= 1'b0;
		@(posedge CLOCK);
		apb(1'b0, 12'h004, 32'h0000_0000);
		check("control", rd, 32'h0000_0000);
		apb(1'b0, 12'h018, 32'h0000_0000);
		check("unmapped", err, 1'b1);
		for (int i = 0; i < 8; i++) begin
			role = 1'($urandom);
			{want.cable_id, want.vbus_above_session} <= 2'($urandom);
			apb(1'b1, 12'h010, {31'h0000_0000, role});
			apb(1'b1, 12'h000, 32'hFFFF_FFFF);
			apb(1'b0, 12'h000, 32'h0000_0000);
			check("status", rd, st(1'b0));
		end
		want.line_se0 <= 1'b1;
		repeat (20010) @(posedge CLOCK);
		apb(1'b0, 12'h000, 32'h0000_0000);
		check("stable", rd, st(1'b1));
		want.line_idle <= 1'b1;
		repeat (3) @(posedge CLOCK);
		apb(1'b0, 12'h000, 32'h0000_0000);
		check("restart", rd, st(1'b0));
		$display("test status done");
		apb(1'b1, 12'h004, 32'h0000_0002);
		apb(1'b0, 12'h004, 32'h0000_0000);
		check("pp clear", rd[1], 1'b0);
		check("token idle", rd[8], 1'b0);
		apb(1'b1, 12'h014, 32'h0000_00A5);
		check("token go", TOKEN_GO, 1'b1);
		apb(1'b1, 12'h014, 32'h0000_003C);
		check("token go drop", TOKEN_GO, 1'b0);
		check("token drop", TOKEN_CMD, 8'hA5);
		do apb(1'b0, 12'h004, 32'h0000_0000); while (rd[8] !== 1'b0);
		apb(1'b1, 12'h014, 32'h0000_003C);
		check("token", TOKEN_CMD, 8'h3C);
		apb(1'b1, 12'h00C, 32'h0000_0001);
		apb(1'b1, 12'h004, 32'h0000_0009);
		count(HOST_LOGIC_RESET, 4);
		check("host reset", n, 1);
		count(FRAME_MARKER, 41000);
		check("markers", n, 2);
		check("module off", MODULE_ON, 1'b0);
		check("irq", IRQ, 1'b1);
		apb(1'b0, 12'h008, 32'h0000_0000);
		check("irq bit", rd[0], 1'b1);
		repeat (2) @(posedge CLOCK);
		check("irq clear", IRQ, 1'b0);
		apb(1'b1, 12'h004, 32'h0000_0008);
		count(FRAME_MARKER, 20100);
		check("markers off", n, 0);
		$display("test host done");
		// Resume hold is kept short; the block leaves its length to software
		apb(1'b1, 12'h004, 32'h0000_0029);
		repeat (2) @(posedge CLOCK);
		check("resume", RESUME_DRIVE, 1'b1);
		apb(1'b1, 12'h004, 32'h0000_0009);
		count(LS_EOP, 6);
		check("eop", n, 1);
		apb(1'b1, 12'h004, 32'h0000_0001);
		count(HOST_LOGIC_RESET, 4);
		check("host reset", n, 1);
		check("module on", MODULE_ON, 1'b1);
		apb(1'b1, 12'h004, 32'h0000_0021);
		apb(1'b1, 12'h004, 32'h0000_0001);
		count(LS_EOP, 6);
		check("no eop", n, 0);
		$display("test resume done");
		RESET <= 1'b1;
		repeat (8) @(posedge CLOCK);
		RESET <= 1'b0;
		@(posedge CLOCK);
		apb(1'b0, 12'h004, 32'h0000_0000);
		check("reset control", rd, 32'h0000_0000);
		check("reset module", MODULE_ON, 1'b0);
		$display("test reset done");
		final_report();
	end
endmodule // tb
